// [srglc_top.sv]
// Symbol rate and gain level configuration block: register file and rate strobes.
// Assumes a plain register port on the 20 MHz crystal clock and datapath inputs
// that are already synchronous to that clock.
//
// Overview of operation
// - Exponent and 20-bit mantissa across three registers
// - Nonzero exponent: rate uses implied leading one
// - Zero exponent: rate is mantissa over 2^38
// - Data rate follows symbol rate per modulation
// - Lower gain when magnitude exceeds reference
// - Carrier threshold is signed, 1 dB steps
// - Signed offset corrects the 12-bit level
module srglc_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  // Datapath samples.
  input wire logic [7:0] chan_mag,
  input wire logic [11:0] rssi_raw,
  // Rate setting seen by the modem.
  output logic [3:0] rate_exponent,
  output logic [19:0] rate_mantissa,
  // Timing strobes.
  output logic sym_stb,
  output logic bit_stb,
  // Gain loop and carrier detect.
  output logic [7:0] gain_loop_target_level,
  output logic [7:0] carrier_detect_level,
  output logic [11:0] level_adj,
  output logic gain_lower,
  output logic carrier_sense
);

  // All state of the top level.
  typedef struct packed {
    srglc_pkg::srglc_regs_t regs;
    logic [7:0] rdata;
    logic [3:0] sym_cnt;
    logic bit_stb;
    logic sym_tgl;
  } srglc_top_state_t;

  // Current and next state.
  srglc_top_state_t q, d;

  // Strobes from the rate generator.
  logic sym_raw;
  logic half_raw;

  // Settings handed to the level logic.
  srglc_pkg::srglc_level_cfg_t lvl_cfg;

  // Decoded modulation and spreading factor.
  srglc_pkg::srglc_mod_t mod;
  logic [3:0] spread;
  logic [3:0] spread_last;

  // Status byte built from live state.
  logic [7:0] status;

  // Rate fields split out of the three rate registers.
  // rate field layout
  assign rate_exponent = q.regs.rate_hi[7:srglc_pkg::EXP_LSB];
  assign rate_mantissa = {q.regs.rate_hi[3:0], q.regs.rate_mid, q.regs.rate_lo};

  // Level settings straight from the registers.
  assign gain_loop_target_level = q.regs.gain_ref;
  assign carrier_detect_level = q.regs.cs_thr;

  // Bundle for the level logic.
  always_comb begin
    lvl_cfg.gain_ref = q.regs.gain_ref;
    lvl_cfg.cs_thr = q.regs.cs_thr;
    lvl_cfg.lvl_off = q.regs.lvl_off;
  end

  // Mode register decode.
  assign mod = srglc_pkg::srglc_mod_t'(q.regs.mode[1:0]);
  assign spread = q.regs.mode[7:srglc_pkg::SF_LSB];

  // A spreading factor of zero behaves as one; the counter stops at factor minus one.
  assign spread_last = (spread == 4'h0) ? 4'h0 : 4'(spread - 4'h1);

  // Status: carrier detect, gain request and symbol toggle.
  always_comb begin
    status = 8'h00;
    status[srglc_pkg::STAT_CS] = carrier_sense;
    status[srglc_pkg::STAT_GL] = gain_lower;
    status[srglc_pkg::STAT_SYM] = q.sym_tgl;
  end

  // Symbol timing generator.
  srglc_rate_gen u_rate (
    .clk(clk),
    .resetn(resetn),
    .exponent(rate_exponent),
    .mantissa(rate_mantissa),
    .sym_stb(sym_raw),
    .half_stb(half_raw)
  );

  // Level correction, gain request and carrier detect.
  srglc_level u_level (
    .clk(clk),
    .resetn(resetn),
    .cfg(lvl_cfg),
    .chan_mag(chan_mag),
    .rssi_raw(rssi_raw),
    .level_adj(level_adj),
    .gain_lower(gain_lower),
    .carrier_sense(carrier_sense)
  );

  // Next state: register writes, read answer and the bit strobe.
  always_comb begin
    d = q;
    d.bit_stb = 1'b0;
    d.rdata = 8'h00;

    // Register writes take effect at the next edge.
    if (reg_we) begin
      unique case (reg_addr)
        srglc_pkg::OFS_RATE_HI: begin
          d.regs.rate_hi = reg_wdata;
        end
        srglc_pkg::OFS_RATE_MID: begin
          d.regs.rate_mid = reg_wdata;
        end
        srglc_pkg::OFS_RATE_LO: begin
          d.regs.rate_lo = reg_wdata;
        end
        srglc_pkg::OFS_GAIN_REF: begin
          d.regs.gain_ref = reg_wdata;
        end
        srglc_pkg::OFS_CS_THR: begin
          d.regs.cs_thr = reg_wdata;
        end
        srglc_pkg::OFS_LVL_OFF: begin
          d.regs.lvl_off = reg_wdata;
        end
        srglc_pkg::OFS_MODE: begin
          d.regs.mode = reg_wdata;
        end
        // Status and unmapped offsets ignore writes.
        default: begin
          d.regs = q.regs;
        end
      endcase
    end

    // Read data stand for one cycle after the read strobe.
    if (reg_re) begin
      unique case (reg_addr)
        srglc_pkg::OFS_RATE_HI: begin
          d.rdata = q.regs.rate_hi;
        end
        srglc_pkg::OFS_RATE_MID: begin
          d.rdata = q.regs.rate_mid;
        end
        srglc_pkg::OFS_RATE_LO: begin
          d.rdata = q.regs.rate_lo;
        end
        srglc_pkg::OFS_GAIN_REF: begin
          d.rdata = q.regs.gain_ref;
        end
        srglc_pkg::OFS_CS_THR: begin
          d.rdata = q.regs.cs_thr;
        end
        srglc_pkg::OFS_LVL_OFF: begin
          d.rdata = q.regs.lvl_off;
        end
        srglc_pkg::OFS_MODE: begin
          d.rdata = q.regs.mode;
        end
        srglc_pkg::OFS_STATUS: begin
          d.rdata = status;
        end
        // Unmapped offsets read as zero.
        default: begin
          d.rdata = 8'h00;
        end
      endcase
    end

    // Each symbol flips the visible toggle.
    if (sym_raw) begin
      d.sym_tgl = !q.sym_tgl;
    end

    unique case (mod)
      // One bit per symbol.
      srglc_pkg::MOD_2LVL: begin
        d.bit_stb = sym_raw;
        d.sym_cnt = 4'h0;
      end
      // Two bits per symbol: at symbol start and at mid-symbol.
      srglc_pkg::MOD_4LVL: begin
        d.bit_stb = sym_raw || half_raw;
        d.sym_cnt = 4'h0;
      end
      // One bit every second symbol, the two chips of one bit.
      srglc_pkg::MOD_MANCH: begin
        if (sym_raw) begin
          d.bit_stb = q.sym_cnt[0];
          d.sym_cnt = {3'h0, !q.sym_cnt[0]};
        end
      end
      // One bit for each full run of spreading chips.
      srglc_pkg::MOD_SPREAD: begin
        if (sym_raw) begin
          if (q.sym_cnt >= spread_last) begin
            d.bit_stb = 1'b1;
            d.sym_cnt = 4'h0;
          end else begin
            d.sym_cnt = 4'(q.sym_cnt + 4'h1);
          end
        end
      end
    endcase
  end

  // State register with the documented power-on values.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q.regs.rate_hi <= srglc_pkg::RST_RATE_HI;
      q.regs.rate_mid <= srglc_pkg::RST_RATE_MID;
      q.regs.rate_lo <= srglc_pkg::RST_RATE_LO;
      q.regs.gain_ref <= srglc_pkg::RST_GAIN_REF;
      q.regs.cs_thr <= srglc_pkg::RST_CS_THR;
      q.regs.lvl_off <= srglc_pkg::RST_LVL_OFF;
      q.regs.mode <= srglc_pkg::RST_MODE;
      q.rdata <= 8'h00;
      q.sym_cnt <= 4'h0;
      q.bit_stb <= 1'b0;
      q.sym_tgl <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Registered outputs.
  assign reg_rdata = q.rdata;
  assign bit_stb = q.bit_stb;

  // Symbol strobe is passed on as the generator makes it.
  assign sym_stb = sym_raw;

  // Exponent and top mantissa follow a write to the top rate register.
  chk_rate_hi_write: assert property (@(posedge clk) disable iff (!resetn)
    reg_we && reg_addr == srglc_pkg::OFS_RATE_HI |=>
    rate_exponent == $past(reg_wdata[7:4]) && rate_mantissa[19:16] == $past(reg_wdata[3:0]))
    else $error("top rate register write not applied");

  // Low mantissa byte lands in bits 7:0.
  chk_rate_lo_write: assert property (@(posedge clk) disable iff (!resetn)
    reg_we && reg_addr == srglc_pkg::OFS_RATE_LO |=> rate_mantissa[7:0] == $past(reg_wdata))
    else $error("low mantissa write not applied");

  // Two-level keying gives one bit per symbol, one cycle later.
  chk_bit_two_level: assert property (@(posedge clk) disable iff (!resetn)
    mod == srglc_pkg::MOD_2LVL && !reg_we ##0 sym_raw |=> bit_stb)
    else $error("two-level bit strobe missing");

  // Manchester gives no bit on two symbols in a row.
  chk_bit_manchester: assert property (@(posedge clk) disable iff (!resetn)
    mod == srglc_pkg::MOD_MANCH && !reg_we && bit_stb |-> !q.sym_cnt[0])
    else $error("manchester bit pairing broken");

  // A read answers in the next cycle with the stored byte.
  chk_read_answer: assert property (@(posedge clk) disable iff (!resetn)
    reg_re && !reg_we && reg_addr == srglc_pkg::OFS_GAIN_REF |=> reg_rdata == $past(q.regs.gain_ref))
    else $error("read data wrong");

  // Middle mantissa byte lands in bits 15:8.
  chk_rate_mid_write: assert property (@(posedge clk) disable iff (!resetn)
    reg_we && reg_addr == srglc_pkg::OFS_RATE_MID |=> rate_mantissa[15:8] == $past(reg_wdata))
    else $error("middle mantissa write not applied");

  // The gain reference seen by the gain loop follows its register write.
  chk_gain_ref_write: assert property (@(posedge clk) disable iff (!resetn)
    reg_we && reg_addr == srglc_pkg::OFS_GAIN_REF |=> gain_loop_target_level == $past(reg_wdata))
    else $error("gain reference write not applied");

  // The carrier threshold follows its register write.
  chk_cs_thr_write: assert property (@(posedge clk) disable iff (!resetn)
    reg_we && reg_addr == srglc_pkg::OFS_CS_THR |=> carrier_detect_level == $past(reg_wdata))
    else $error("carrier threshold write not applied");

  // The level offset handed to the level logic follows its register write.
  chk_offset_write: assert property (@(posedge clk) disable iff (!resetn)
    reg_we && reg_addr == srglc_pkg::OFS_LVL_OFF |=> lvl_cfg.lvl_off == $past(reg_wdata))
    else $error("level offset write not applied");

  // Without a write strobe every setting holds its value.
  chk_regs_hold: assert property (@(posedge clk) disable iff (!resetn)
    !reg_we |=> q.regs == $past(q.regs))
    else $error("settings changed without a write");

  // Writes to the status and unmapped offsets change no setting.
  chk_status_ro: assert property (@(posedge clk) disable iff (!resetn)
    reg_we && reg_addr >= srglc_pkg::OFS_STATUS |=> q.regs == $past(q.regs))
    else $error("read-only offset took a write");

  // Read data are zero in any cycle that does not follow a read strobe.
  chk_read_idle: assert property (@(posedge clk) disable iff (!resetn)
    !reg_re |=> reg_rdata == 8'h00)
    else $error("read data outside the answer cycle");

  // Unmapped offsets read as zero.
  chk_read_unmapped: assert property (@(posedge clk) disable iff (!resetn)
    reg_re && reg_addr[3] |=> reg_rdata == 8'h00)
    else $error("unmapped offset read not zero");

  // The status byte carries carrier detect, gain request and symbol toggle.
  chk_read_status: assert property (@(posedge clk) disable iff (!resetn)
    reg_re && reg_addr == srglc_pkg::OFS_STATUS |=>
    reg_rdata == {5'h00, $past(q.sym_tgl), $past(gain_lower), $past(carrier_sense)})
    else $error("status read wrong");

  // Four-level keying gives a bit at symbol start and at mid-symbol.
  chk_bit_four_level: assert property (@(posedge clk) disable iff (!resetn)
    mod == srglc_pkg::MOD_4LVL && (sym_raw || half_raw) |=> bit_stb)
    else $error("four-level bit strobe missing");

  // Outside four-level keying a bit only ever follows a symbol.
  chk_bit_needs_sym: assert property (@(posedge clk) disable iff (!resetn)
    mod != srglc_pkg::MOD_4LVL && !sym_raw |=> !bit_stb)
    else $error("bit strobe without a symbol");

  // Each symbol flips the status toggle.
  chk_sym_toggle: assert property (@(posedge clk) disable iff (!resetn)
    sym_raw |=> q.sym_tgl != $past(q.sym_tgl))
    else $error("symbol toggle did not flip");

endmodule

// [srglc_pkg.sv]
// Shared constants, types and helper functions of the rate and level config block.
// Assumes one 20 MHz crystal clock and an active-low asynchronous reset.
package srglc_pkg;

  // Register port widths.
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // Register offsets.
  localparam logic [3:0] OFS_RATE_HI = 4'h0;
  localparam logic [3:0] OFS_RATE_MID = 4'h1;
  localparam logic [3:0] OFS_RATE_LO = 4'h2;
  localparam logic [3:0] OFS_GAIN_REF = 4'h3;
  localparam logic [3:0] OFS_CS_THR = 4'h4;
  localparam logic [3:0] OFS_LVL_OFF = 4'h5;
  localparam logic [3:0] OFS_MODE = 4'h6;
  localparam logic [3:0] OFS_STATUS = 4'h7;

  // Reset values.
  localparam logic [7:0] RST_RATE_HI = 8'h43;
  localparam logic [7:0] RST_RATE_MID = 8'hA9;
  localparam logic [7:0] RST_RATE_LO = 8'h2A;
  localparam logic [7:0] RST_GAIN_REF = 8'h36;
  localparam logic [7:0] RST_CS_THR = 8'h00;
  localparam logic [7:0] RST_LVL_OFF = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h10;

  // Field positions.
  localparam int unsigned EXP_LSB = 4;
  localparam int unsigned SF_LSB = 4;
  localparam int unsigned STAT_CS = 0;
  localparam int unsigned STAT_GL = 1;
  localparam int unsigned STAT_SYM = 2;

  // Datapath widths.
  localparam int unsigned MANT_W = 20;
  localparam int unsigned ACC_W = 39;
  localparam int unsigned LEVEL_W = 12;

  // Modulation formats, which set bits per symbol.
  typedef enum logic [1:0] {MOD_2LVL, MOD_4LVL, MOD_MANCH, MOD_SPREAD} srglc_mod_t;

  // Software-visible register set.
  typedef struct packed {
    logic [7:0] rate_hi;
    logic [7:0] rate_mid;
    logic [7:0] rate_lo;
    logic [7:0] gain_ref;
    logic [7:0] cs_thr;
    logic [7:0] lvl_off;
    logic [7:0] mode;
  } srglc_regs_t;

  // Settings that the level logic needs.
  typedef struct packed {
    logic [7:0] gain_ref;
    logic [7:0] cs_thr;
    logic [7:0] lvl_off;
  } srglc_level_cfg_t;

  // Phase step per crystal cycle, scaled so that overflow of 2^39 is one symbol.
  function automatic logic [38:0] srglc_rate_incr(input logic [3:0] e, input logic [19:0] m);
    logic [38:0] base;
    base = {18'h0, 1'b1, m};
    if (e == 4'h0) begin
      return {18'h0, m, 1'b0};
    end
    return base << e;
  endfunction

  // Sign-extends a byte in 1 dB steps to the level width.
  function automatic logic [11:0] srglc_sext8(input logic [7:0] v);
    return {{4{v[7]}}, v};
  endfunction

endpackage

// [srglc_rate_gen.sv]
// Symbol timing generator: a phase accumulator stepped once per crystal cycle.
// Assumes exponent and mantissa come from registers on the same clock.
module srglc_rate_gen (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Rate setting.
  input wire logic [3:0] exponent,
  input wire logic [19:0] mantissa,
  // Strobes at symbol start and at mid-symbol.
  output logic sym_stb,
  output logic half_stb
);

  // All state of the generator.
  typedef struct packed {
    logic [38:0] acc;
    logic sym;
    logic half;
  } srglc_rg_state_t;

  srglc_rg_state_t q, d;
  logic [38:0] incr;
  logic [39:0] sum;

  // Step size follows the exponent; a zero exponent drops the implied leading one.
  // exponent selects step
  assign incr = srglc_pkg::srglc_rate_incr(exponent, mantissa);
  assign sum = {1'b0, q.acc} + {1'b0, incr};

  // Next state: overflow marks a symbol, crossing half scale marks mid-symbol.
  always_comb begin
    d = q;
    d.acc = sum[38:0];
    d.sym = sum[39];
    d.half = !sum[39] && !q.acc[38] && sum[38];
  end

  // State register.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sym_stb = q.sym;
  assign half_stb = q.half;

  // Phase advances by the mantissa with the implied one when the exponent is set.
  chk_step_normal: assert property (@(posedge clk) disable iff (!resetn)
    $past(exponent) != 4'h0 && $past(resetn) |->
    q.acc == 39'($past(q.acc) + (({18'h0, 1'b1, $past(mantissa)}) << $past(exponent))))
    else $error("phase step wrong for nonzero exponent");

  // Phase advances by twice the bare mantissa when the exponent is zero.
  chk_step_zero: assert property (@(posedge clk) disable iff (!resetn)
    $past(exponent) == 4'h0 && $past(resetn) |->
    q.acc == 39'($past(q.acc) + {$past(mantissa), 1'b0}))
    else $error("phase step wrong for zero exponent");

  // A symbol strobe appears exactly when the phase wraps.
  chk_sym_wrap: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn) |-> (sym_stb == (q.acc < $past(q.acc))))
    else $error("symbol strobe not tied to phase wrap");

endmodule

// [srglc_level.sv]
// Received level correction, gain reduction request and carrier detect.
// Assumes magnitude and raw level arrive from datapath logic on the same clock.
module srglc_level (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Settings.
  input wire srglc_pkg::srglc_level_cfg_t cfg,
  // Datapath samples.
  input wire logic [7:0] chan_mag,
  input wire logic [11:0] rssi_raw,
  // Results.
  output logic [11:0] level_adj,
  output logic gain_lower,
  output logic carrier_sense
);

  // All state of the level logic.
  typedef struct packed {
    logic [11:0] lvl;
    logic lower;
    logic cs;
  } srglc_lv_state_t;

  srglc_lv_state_t q, d;
  logic [11:0] corr;

  // Corrected level, offset added in 1 dB steps.
  assign corr = rssi_raw + srglc_pkg::srglc_sext8(cfg.lvl_off);

  // Next state of the three results.
  always_comb begin
    d = q;
    d.lvl = corr;
    d.lower = chan_mag > cfg.gain_ref;
    d.cs = $signed(corr) >= $signed(srglc_pkg::srglc_sext8(cfg.cs_thr));
  end

  // State register.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level_adj = q.lvl;
  assign gain_lower = q.lower;
  assign carrier_sense = q.cs;

  // Gain is asked down one cycle after magnitude exceeds the reference.
  chk_gain_lower: assert property (@(posedge clk) disable iff (!resetn)
    chan_mag > cfg.gain_ref |=> gain_lower) else $error("gain not lowered above reference");

  // Carrier detect follows the signed comparison one cycle later.
  chk_carrier_cmp: assert property (@(posedge clk) disable iff (!resetn)
    $signed(level_adj) < $signed({{4{$past(cfg.cs_thr[7])}}, $past(cfg.cs_thr)}) |-> !carrier_sense)
    else $error("carrier detected below signed threshold");

  // Corrected level equals raw reading plus the signed offset.
  chk_level_sum: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn) |-> level_adj == 12'($past(rssi_raw) + {{4{$past(cfg.lvl_off[7])}}, $past(cfg.lvl_off)}))
    else $error("level offset not applied");

endmodule

// [test_symbol_rate_and_gain_level_config.sv]
// Self-checking bench for the symbol rate and gain level configuration block.
// Assumes the design package and top module are compiled before this file.
module test_symbol_rate_and_gain_level_config;
  timeunit 1ns;
  timeprecision 1ps;

  // Clock, reset and register port.
  logic clk;
  logic resetn;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_we;
  logic reg_re;
  logic [7:0] reg_rdata;
  // Datapath samples and results.
  logic [7:0] chan_mag;
  logic [11:0] rssi_raw;
  logic [3:0] rate_exponent;
  logic [19:0] rate_mantissa;
  logic sym_stb;
  logic bit_stb;
  logic [7:0] gain_loop_target_level;
  logic [7:0] carrier_detect_level;
  logic [11:0] level_adj;
  logic gain_lower;
  logic carrier_sense;
  // Counters and the seed of the random stimulus.
  int fail_count;
  int checks;
  int seed;
  // Bench model of the writable registers.
  logic [7:0] shadow [0:6];

  srglc_top u_dut (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .chan_mag(chan_mag),
    .rssi_raw(rssi_raw), .rate_exponent(rate_exponent), .rate_mantissa(rate_mantissa),
    .sym_stb(sym_stb), .bit_stb(bit_stb), .gain_loop_target_level(gain_loop_target_level),
    .carrier_detect_level(carrier_detect_level), .level_adj(level_adj),
    .gain_lower(gain_lower), .carrier_sense(carrier_sense)
  );

  // Free-running 20 MHz clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Compares a design value; as wide as the widest result, zero-extended.
  task automatic cmpv(input logic [19:0] got, input logic [19:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  // Compares a count measured by the bench against a range.
  task automatic cmpn(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("ERROR %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // One-cycle write; the model ignores the read-only and unmapped offsets.
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
    if (a < 4'h7) begin
      shadow[a] = d;
    end
  endtask

  // One-cycle read; data is taken in the cycle after the strobe.
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  // Counts cycles up to the next symbol strobe, with a bound.
  task automatic wait_sym(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (sym_stb !== 1'b1 && n < 10000);
    if (n >= 10000) begin
      fail_count++;
      $display("ERROR %0t symbol strobe missing", $time);
      conclude();
    end
  endtask

  // Model of the carrier decision on the corrected level.
  function automatic logic cs_model(input logic [11:0] rs, input logic [7:0] th, input logic [7:0] of);
    logic [11:0] adj;
    adj = rs + {{4{of[7]}}, of};
    return $signed(adj) >= $signed({{4{th[7]}}, th});
  endfunction

  initial begin
    logic [7:0] d;
    logic [7:0] m;
    logic [7:0] pm;
    logic [11:0] r;
    logic [11:0] pr;
    int n;
    int syms;
    int bits;
    int ex;
    longint incr;
    longint lo;
    int te [0:4];
    int tm [0:4];
    seed = 25;
    fail_count = 0;
    checks = 0;
    resetn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
    chan_mag = 8'h00;
    rssi_raw = 12'h000;
    shadow = '{8'h43, 8'hA9, 8'h2A, 8'h36, 8'h00, 8'h00, srglc_pkg::RST_MODE};
    te = '{15, 14, 15, 12, 6};
    tm = '{0, 0, 'h80000, 'hFFFFF, 0};
    repeat (2) @(posedge clk);
    resetn <= 1'b1;

    // Reset values, unmapped reads, ignored writes and random read-back.
    for (int a = 0; a < 7; a++) begin
      reg_rd(a[3:0], d);
      cmpv(d, shadow[a]);
    end
    reg_rd(4'h8, d);
    cmpv(d, 0);
    @(negedge clk);
    cmpv(reg_rdata, 0);
    cmpv(rate_exponent, 4'h4);
    cmpv(rate_mantissa, 20'h3_A92A);
    reg_wr(4'h7, 8'hFF);
    reg_wr(4'hC, 8'hFF);
    for (int a = 0; a < 7; a++) begin
      reg_wr(a[3:0], 8'($random(seed)));
    end
    for (int a = 0; a < 8; a++) begin
      reg_rd(4'(a + 8 * (a / 7)), d);
      cmpv(d, (a == 7) ? 8'h00 : shadow[a]);
    end
    cmpv(rate_exponent, shadow[0][7:4]);
    cmpv(rate_mantissa, {shadow[0][3:0], shadow[1], shadow[2]});
    $display("test registers done");

    // Strobe spacing for several exponents and mantissas.
    reg_wr(4'h6, 8'h00);
    for (int i = 0; i < 5; i++) begin
      reg_wr(4'h0, {te[i][3:0], tm[i][19:16]});
      reg_wr(4'h1, tm[i][15:8]);
      reg_wr(4'h2, tm[i][7:0]);
      incr = ((64'd1 << 20) + tm[i]) << te[i];
      lo = (64'd1 << 39) / incr;
      wait_sym(n);
      repeat (2) begin
        wait_sym(n);
        cmpn(n, int'(lo), int'(lo) + (((64'd1 << 39) % incr) != 0));
      end
    end
    // Zero exponent: the phase moves by twice the bare mantissa each cycle.
    reg_wr(4'h0, 8'h0F);
    @(negedge clk);
    lo = longint'(u_dut.u_rate.q.acc);
    repeat (10) @(negedge clk);
    incr = (longint'(u_dut.u_rate.q.acc) - lo) & ((64'd1 << 39) - 1);
    cmpn(int'(incr), 20 * 32'h000F_0000, 20 * 32'h000F_0000);
    $display("test rate done");

    // Bit strobes per symbol for every modulation format.
    reg_wr(4'h0, 8'hF0);
    reg_wr(4'h1, 8'h00);
    reg_wr(4'h2, 8'h00);
    for (int md = 0; md < 4; md++) begin
      reg_wr(4'h6, (md == 3) ? 8'h43 : 8'(md));
      wait_sym(n);
      syms = 0;
      bits = 0;
      repeat (640) begin
        @(negedge clk);
        syms += (sym_stb === 1'b1);
        bits += (bit_stb === 1'b1);
      end
      ex = (md == 0) ? 40 : (md == 1) ? 80 : (md == 2) ? 20 : 10;
      cmpn(syms, 40, 40);
      cmpn(bits, ex - 1, ex + 1);
    end
    $display("test modulation done");

    // Mid-run reset brings back the power-on settings and quiet outputs.
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    shadow = '{8'h43, 8'hA9, 8'h2A, 8'h36, 8'h00, 8'h00, srglc_pkg::RST_MODE};
    cmpv(rate_exponent, 4'h4);
    cmpv(rate_mantissa, 20'h3_A92A);
    cmpv(gain_loop_target_level, 8'h36);
    cmpv(carrier_detect_level, 8'h00);
    cmpv(level_adj, 12'h000);
    cmpv({gain_lower, carrier_sense, sym_stb, bit_stb, reg_rdata}, 12'h000);
    $display("test reset done");

    // Level correction, gain reduction and carrier detect with boundary samples.
    for (int b = 0; b < 3; b++) begin
      // Rule-of-thumb references first, then one raised at random into 0x32..0x41.
      m = (b == 0) ? 8'h24 : (b == 1) ? 8'h31 : 8'(8'h32 + ($random(seed) & 15));
      reg_wr(4'h3, m);
      reg_wr(4'h4, 8'($random(seed)));
      reg_wr(4'h5, 8'($random(seed)));
      @(negedge clk);
      cmpv(gain_loop_target_level, shadow[3]);
      cmpv(carrier_detect_level, shadow[4]);
      m = 8'h00;
      r = 12'h000;
      for (int k = 0; k < 60; k++) begin
        @(posedge clk);
        chan_mag <= m;
        rssi_raw <= r;
        @(negedge clk);
        if (k > 0) begin
          cmpv(level_adj, 12'(pr + {{4{shadow[5][7]}}, shadow[5]}));
          cmpv(gain_lower, pm > shadow[3]);
          cmpv(carrier_sense, cs_model(pr, shadow[4], shadow[5]));
        end
        pm = m;
        pr = r;
        m = (k % 3 == 1) ? shadow[3] : 8'($random(seed));
        r = {{4{shadow[4][7]}}, shadow[4]} - {{4{shadow[5][7]}}, shadow[5]} - 12'(k % 4 == 3);
        if (k % 4 == 0) begin
          r = 12'($random(seed));
        end
      end
      reg_rd(4'h7, d);
      cmpv(d[1:0], {pm > shadow[3], cs_model(pr, shadow[4], shadow[5])});
    end
    $display("test level done");
    conclude();
  end
endmodule
